// ---- hdl/osp_ctrl.sv ----
`timescale 1ns/100ps
module osp_ctrl
   import osp_pkg::*;
(
   input  wire logic              clk_sys,       // system clock, 125 MHz
   input  wire logic              rstn,          // sync reset, active low
   input  wire logic              cs_n_pin,      // chip select pin
   input  wire logic              sclk_pin,      // serial clock pin
   input  wire logic [3:0]        sio_i,         // data lines in
   output logic      [3:0]        sio_o,         // data lines out
   output logic      [3:0]        sio_oe,        // data line enables
   input  wire logic              wp_n_pin,      // write-protect pin
   input  wire logic              factory_lock,  // factory lock strap
   input  wire logic              quad_command_mode, // quad command mode
   input  wire logic              bp_range_hit,  // block_protect_bits cover target
   input  wire logic              persistent_protect_bit, // target persistent bit
   input  wire logic              volatile_protect_bit,   // target volatile bit
   input  osp_pkg::osp_evt_t      evt,           // engine events
   output osp_pkg::osp_prot_t     prot,          // protection view
   output logic                   write_enable_latch, // write-enable latch
   output logic      [7:0]        security_register   // current register value
);
   import osp_pkg::*;

   logic [7:0] sync_in;
   logic [7:0] sync_out;
   logic       cs_n_s;
   logic       sclk_s;
   logic       wp_n_s;
   logic       factory_s;
   logic [3:0] sio_s;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       frame_beg;
   logic       frame_end;

   assign sync_in = {factory_lock, wp_n_pin, sio_i, sclk_pin, cs_n_pin};

   osp_sync #(.W(OSP_SYNC_W)) u_sync (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .d_in    (sync_in),
      .rst_val (8'h61),
      .d_out   (sync_out)
   );

   assign cs_n_s    = sync_out[0];
   assign sclk_s    = sync_out[1];
   assign sio_s     = sync_out[5:2];
   assign wp_n_s    = sync_out[6];
   assign factory_s = sync_out[7];

   osp_link_edges u_edges (
      .clk_sys   (clk_sys),
      .rstn      (rstn),
      .sclk_s    (sclk_s),
      .cs_n_s    (cs_n_s),
      .sclk_rise (sclk_rise),
      .sclk_fall (sclk_fall),
      .frame_beg (frame_beg),
      .frame_end (frame_end)
   );

   function automatic osp_cmd_t decode(input logic [7:0] op);
      if (op == OSP_OP_ENTER_OTP) begin
         return OSP_CMD_ENTER;
      end else if (op == OSP_OP_EXIT_OTP) begin
         return OSP_CMD_EXIT;
      end else if (op == OSP_OP_READ_SEC) begin
         return OSP_CMD_READ;
      end else if (op == OSP_OP_WRITE_SEC) begin
         return OSP_CMD_WSEC;
      end else if (op == OSP_OP_WRITE_ENABLE_CMD) begin
         return OSP_CMD_WRITE_ENABLE_CMD;
      end else if (op == OSP_OP_MODE_SEL) begin
         return OSP_CMD_MSEL;
      end else begin
         return OSP_CMD_NONE;
      end
   endfunction

   // ---------------- opcode capture ----------------
   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;
   logic [7:0] op_reg;
   logic [3:0] step;
   logic       quad_reg;

   // mode is frozen per frame so a mid-frame change cannot split an opcode
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         quad_reg <= 1'b0;
      end else if (frame_beg) begin
         quad_reg <= quad_command_mode;
      end
   end

   assign step = quad_reg ? OSP_STEP_QUAD : OSP_STEP_SINGLE;

   always_comb begin
      cnt_next = cnt_reg;
      if (frame_beg) begin
         cnt_next = 4'h0;
      end else if (sclk_rise) begin
         if (cnt_reg > OSP_CNT_MAX - step) begin
            cnt_next = OSP_CNT_MAX;
         end else begin
            cnt_next = cnt_reg + step;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         cnt_reg <= 4'h0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         op_reg <= OSP_RST_BYTE;
      end else if (sclk_rise && cnt_reg < OSP_OPCODE_BITS) begin
         if (quad_reg) begin
            op_reg <= {op_reg[3:0], sio_s};
         end else begin
            op_reg <= {op_reg[6:0], sio_s[0]};
         end
      end
   end

   osp_cmd_t cmd;
   logic     on_boundary;
   logic     exec;

   assign cmd         = decode(op_reg);
   assign on_boundary = (cnt_reg == OSP_OPCODE_BITS);
   assign exec        = frame_end & on_boundary;

   // ---------------- security register state ----------------
   logic otp_mode_reg;
   logic wel_reg;
   logic lockdown_reg;
   logic modesel_reg;
   logic efail_reg;
   logic pfail_reg;
   logic esusp_reg;
   logic psusp_reg;
   logic preset_reg;
   logic started_reg;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         otp_mode_reg <= 1'b0;
      end else if (exec && cmd == OSP_CMD_ENTER) begin
         otp_mode_reg <= 1'b1;
      end else if (exec && cmd == OSP_CMD_EXIT) begin
         otp_mode_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         wel_reg <= 1'b0;
      end else if (exec && cmd == OSP_CMD_WRITE_ENABLE_CMD) begin
         wel_reg <= 1'b1;
      end else if (exec && (cmd == OSP_CMD_WSEC || cmd == OSP_CMD_MSEL)) begin
         wel_reg <= 1'b0;
      end
   end

   // no clear path exists: a one-way bit
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         lockdown_reg <= OSP_RST_LOCK;
      end else if (exec && cmd == OSP_CMD_WSEC && wel_reg) begin
         lockdown_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         modesel_reg <= OSP_RST_MODESEL;
      end else if (exec && cmd == OSP_CMD_MSEL && wel_reg) begin
         modesel_reg <= 1'b1;
      end
   end

   // set wins over clear when both arrive together
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         efail_reg <= OSP_RST_FLAG;
      end else if (evt.erase_fail) begin
         efail_reg <= 1'b1;
      end else if (evt.erase_ok || evt.prog_ok) begin
         efail_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         pfail_reg <= OSP_RST_FLAG;
      end else if (evt.prog_fail) begin
         pfail_reg <= 1'b1;
      end else if (evt.erase_ok || evt.prog_ok) begin
         pfail_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         esusp_reg <= OSP_RST_FLAG;
      end else if (evt.erase_susp) begin
         esusp_reg <= 1'b1;
      end else if (evt.erase_resume) begin
         esusp_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         psusp_reg <= OSP_RST_FLAG;
      end else if (evt.prog_susp) begin
         psusp_reg <= 1'b1;
      end else if (evt.prog_resume) begin
         psusp_reg <= 1'b0;
      end
   end

   // one pulse after reset release asks the array to set all volatile bits
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         started_reg <= 1'b0;
         preset_reg  <= 1'b0;
      end else begin
         started_reg <= 1'b1;
         preset_reg  <= ~started_reg;
      end
   end

   always_comb begin
      security_register                   = OSP_RST_BYTE;
      security_register[OSP_BIT_FACTORY]  = factory_s;
      security_register[OSP_BIT_LOCKDOWN] = lockdown_reg;
      security_register[OSP_BIT_PSUSP]    = psusp_reg;
      security_register[OSP_BIT_ESUSP]    = esusp_reg;
      security_register[OSP_BIT_RSVD]     = 1'b0;
      security_register[OSP_BIT_PFAIL]    = pfail_reg;
      security_register[OSP_BIT_EFAIL]    = efail_reg;
      security_register[OSP_BIT_MODESEL]  = modesel_reg;
   end

   assign write_enable_latch = wel_reg;

   // ---------------- protection view ----------------
   logic array_wp;

   always_comb begin
      if (modesel_reg) begin
         array_wp = ~wp_n_s | persistent_protect_bit | volatile_protect_bit;
      end else begin
         array_wp = bp_range_hit;
      end
   end

   assign prot.otp_mode        = otp_mode_reg;
   assign prot.otp_write_ok    = otp_mode_reg & ~lockdown_reg;
   assign prot.array_wp        = array_wp;
   assign prot.indiv_cmd_en    = modesel_reg;
   assign prot.volatile_preset = preset_reg;

   // ---------------- register read-out ----------------
   // busy state is never consulted here, so reads work during any operation
   logic       rd_arm_reg;
   logic       rd_act_reg;
   logic [7:0] out_sh_reg;
   logic [3:0] out_bits_reg;

   always_ff @(posedge clk_sys) begin
      if (!rstn || frame_beg || frame_end) begin
         rd_arm_reg <= 1'b0;
      end else if (sclk_rise && cnt_next == OSP_OPCODE_BITS &&
                   decode(quad_reg ? {op_reg[3:0], sio_s} : {op_reg[6:0], sio_s[0]})
                   == OSP_CMD_READ) begin
         rd_arm_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn || frame_end) begin
         rd_act_reg   <= 1'b0;
         out_sh_reg   <= OSP_RST_BYTE;
         out_bits_reg <= 4'h0;
      end else if (sclk_fall && rd_arm_reg) begin
         rd_act_reg <= 1'b1;
         if (out_bits_reg == 4'h0) begin
            // reload a fresh copy each byte so live flags are seen
            out_sh_reg   <= quad_reg ? {security_register[3:0], 4'h0}
                                     : {security_register[6:0], 1'b0};
            out_bits_reg <= OSP_OPCODE_BITS - step;
         end else begin
            out_sh_reg   <= quad_reg ? {out_sh_reg[3:0], 4'h0}
                                     : {out_sh_reg[6:0], 1'b0};
            out_bits_reg <= out_bits_reg - step;
         end
      end
   end

   logic [3:0] sio_o_reg;

   always_ff @(posedge clk_sys) begin
      if (!rstn || frame_end) begin
         sio_o_reg <= 4'h0;
      end else if (sclk_fall && rd_arm_reg) begin
         if (out_bits_reg == 4'h0) begin
            sio_o_reg <= quad_reg ? security_register[7:4]
                                  : {2'b00, security_register[7], 1'b0};
         end else begin
            sio_o_reg <= quad_reg ? out_sh_reg[7:4] : {2'b00, out_sh_reg[7], 1'b0};
         end
      end
   end

   assign sio_o  = sio_o_reg;
   assign sio_oe = rd_act_reg ? (quad_reg ? 4'hf : 4'h2) : 4'h0;

   // ---------------- checks ----------------
   sequence s_exec_enter;
      exec && cmd == OSP_CMD_ENTER;
   endsequence

   sequence s_exec_exit;
      exec && cmd == OSP_CMD_EXIT;
   endsequence

   property p_enter;
      @(posedge clk_sys) disable iff (!rstn) s_exec_enter |=> otp_mode_reg;
   endproperty
   a_enter: assert property (p_enter) else $error("otp mode not entered");

   property p_exit;
      @(posedge clk_sys) disable iff (!rstn) s_exec_exit |=> !otp_mode_reg;
   endproperty
   a_exit: assert property (p_exit) else $error("otp mode not left");

   property p_persist;
      @(posedge clk_sys) disable iff (!rstn)
         $fell(otp_mode_reg) |-> $past(exec) && $past(cmd) == OSP_CMD_EXIT;
   endproperty
   a_persist: assert property (p_persist) else $error("otp mode lost");

   property p_lock_hold;
      @(posedge clk_sys) disable iff (!rstn) !$fell(lockdown_reg);
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("lockdown cleared");

   property p_wsec_needs_wel;
      @(posedge clk_sys) disable iff (!rstn)
         $rose(lockdown_reg) |-> $past(wel_reg) && $past(on_boundary);
   endproperty
   a_wsec_needs_wel: assert property (p_wsec_needs_wel) else $error("bad lockdown");

   property p_msel_one_way;
      @(posedge clk_sys) disable iff (!rstn)
         modesel_reg |=> modesel_reg [*3];
   endproperty
   a_msel_one_way: assert property (p_msel_one_way) else $error("mode select fell");

   property p_wp_pin;
      @(posedge clk_sys) disable iff (!rstn) modesel_reg && !wp_n_s |-> prot.array_wp;
   endproperty
   a_wp_pin: assert property (p_wp_pin) else $error("pin protect missed");

   property p_bp_mode;
      @(posedge clk_sys) disable iff (!rstn) !modesel_reg |-> prot.array_wp == bp_range_hit;
   endproperty
   a_bp_mode: assert property (p_bp_mode) else $error("bp mode wrong");

   property p_otp_locked;
      @(posedge clk_sys) disable iff (!rstn) lockdown_reg |-> !prot.otp_write_ok;
   endproperty
   a_otp_locked: assert property (p_otp_locked) else $error("locked otp writable");

   property p_efail;
      @(posedge clk_sys) disable iff (!rstn)
         evt.erase_fail |=> security_register[OSP_BIT_EFAIL] ##1 1'b1;
   endproperty
   a_efail: assert property (p_efail) else $error("erase fail lost");

   property p_esusp;
      @(posedge clk_sys) disable iff (!rstn)
         evt.erase_resume && !evt.erase_susp |=> !security_register[OSP_BIT_ESUSP];
   endproperty
   a_esusp: assert property (p_esusp) else $error("erase suspend not cleared");

   property p_rsvd;
      @(posedge clk_sys) disable iff (!rstn) !security_register[OSP_BIT_RSVD];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

   // enabling the sector commands must trace back to an accepted mode-select frame
   property p_indiv;
      @(posedge clk_sys) disable iff (!rstn)
         $rose(prot.indiv_cmd_en) |-> $past(exec) && $past(cmd) == OSP_CMD_MSEL && $past(wel_reg);
   endproperty
   a_indiv: assert property (p_indiv) else $error("indiv enable mismatch");
endmodule

// ---- hdl/osp_pkg.sv ----
package osp_pkg;
   // command opcodes
   localparam logic [7:0] OSP_OP_ENTER_OTP = 8'hb1;
   localparam logic [7:0] OSP_OP_EXIT_OTP  = 8'hc1;
   localparam logic [7:0] OSP_OP_READ_SEC  = 8'h2b;
   localparam logic [7:0] OSP_OP_WRITE_SEC = 8'h2f;
   localparam logic [7:0] OSP_OP_WRITE_ENABLE_CMD      = 8'h06;
   localparam logic [7:0] OSP_OP_MODE_SEL  = 8'h68;

   // security register field positions
   localparam int OSP_BIT_FACTORY  = 0;
   localparam int OSP_BIT_LOCKDOWN = 1;
   localparam int OSP_BIT_PSUSP    = 2;
   localparam int OSP_BIT_ESUSP    = 3;
   localparam int OSP_BIT_RSVD     = 4;
   localparam int OSP_BIT_PFAIL    = 5;
   localparam int OSP_BIT_EFAIL    = 6;
   localparam int OSP_BIT_MODESEL  = 7;

   // reset values
   localparam logic       OSP_RST_FLAG    = 1'b0;
   localparam logic       OSP_RST_MODESEL = 1'b0;
   localparam logic       OSP_RST_LOCK    = 1'b0;
   localparam logic [7:0] OSP_RST_BYTE    = 8'h00;

   // link counts: bits per opcode, bits per sclk edge in each mode
   localparam logic [3:0] OSP_OPCODE_BITS = 4'h8;
   localparam logic [3:0] OSP_STEP_SINGLE = 4'h1;
   localparam logic [3:0] OSP_STEP_QUAD   = 4'h4;
   localparam logic [3:0] OSP_CNT_MAX     = 4'hf;
   localparam int         OSP_SYNC_W      = 8;

   typedef enum logic [2:0] {
      OSP_CMD_NONE  = 3'b000,
      OSP_CMD_ENTER = 3'b001,
      OSP_CMD_EXIT  = 3'b010,
      OSP_CMD_READ  = 3'b011,
      OSP_CMD_WSEC  = 3'b100,
      OSP_CMD_WRITE_ENABLE_CMD  = 3'b101,
      OSP_CMD_MSEL  = 3'b110
   } osp_cmd_t;

   // events from the program/erase engine, one-cycle pulses
   typedef struct packed {
      logic erase_fail;
      logic erase_ok;
      logic prog_fail;
      logic prog_ok;
      logic erase_susp;
      logic erase_resume;
      logic prog_susp;
      logic prog_resume;
   } osp_evt_t;

   // protection view handed to the array logic
   typedef struct packed {
      logic otp_mode;
      logic otp_write_ok;
      logic array_wp;
      logic indiv_cmd_en;
      logic volatile_preset;
   } osp_prot_t;
endpackage

// ---- hdl/osp_sync.sv ----
`timescale 1ns/100ps
module osp_sync #(
   parameter int W = 8
) (
   input  wire logic         clk_sys, // system clock
   input  wire logic         rstn,    // sync reset, active low
   input  wire logic [W-1:0] d_in,    // asynchronous inputs
   input  wire logic [W-1:0] rst_val, // constant value held in reset
   output logic      [W-1:0] d_out    // synchronised outputs
);
   logic [W-1:0] stage1_reg;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk_sys) begin
            if (!rstn) begin
               stage1_reg[i] <= rst_val[i];
               d_out[i]      <= rst_val[i];
            end else begin
               stage1_reg[i] <= d_in[i];
               d_out[i]      <= stage1_reg[i];
            end
         end
      end
   endgenerate
endmodule

// ---- hdl/osp_link_edges.sv ----
`timescale 1ns/100ps
module osp_link_edges (
   input  wire logic clk_sys,   // system clock
   input  wire logic rstn,      // sync reset, active low
   input  wire logic sclk_s,    // synchronised serial clock
   input  wire logic cs_n_s,    // synchronised chip select
   output logic      sclk_rise, // pulse: serial clock rose inside a frame
   output logic      sclk_fall, // pulse: serial clock fell inside a frame
   output logic      frame_beg, // pulse: chip select fell
   output logic      frame_end  // pulse: chip select rose
);
   logic sclk_d_reg;
   logic cs_n_d_reg;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         sclk_d_reg <= 1'b0;
         cs_n_d_reg <= 1'b1;
      end else begin
         sclk_d_reg <= sclk_s;
         cs_n_d_reg <= cs_n_s;
      end
   end

   // edges outside a frame are meaningless to the command logic
   assign sclk_rise = sclk_s & ~sclk_d_reg & ~cs_n_s;
   assign sclk_fall = ~sclk_s & sclk_d_reg & ~cs_n_s;
   assign frame_beg = ~cs_n_s & cs_n_d_reg;
   assign frame_end = cs_n_s & ~cs_n_d_reg;
endmodule

// ---- testbench/osp_host_model.sv ----
`timescale 1ns/100ps
module osp_host_model (
   input  wire logic       clk_sys,          // system clock
   output logic            cs_n_pin,         // chip select, active low
   output logic            sclk_pin,         // serial clock, still between frames
   output logic [3:0]      sio_i,            // data lines to the device
   input  wire logic [3:0] sio_o,            // data lines from the device
   input  wire logic [3:0] sio_oe,           // device drive enables
   output logic            quad_command_mode // quad command mode
);
   logic [15:0] rd_q;
   logic [3:0]  oe_seen;
   initial begin
      cs_n_pin = 1'b1;
      sclk_pin = 1'b0;
      sio_i = 4'ha;
      quad_command_mode = 1'b0;
      rd_q = 16'h0000;
      oe_seen = 4'h0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // beats beyond the opcode collect read data; odd counts probe refusal
   task automatic frame(input logic [7:0] op, input int beats, input logic quad);
      logic [7:0] sh;
      sh = op;
      tick(1);
      quad_command_mode <= quad;
      cs_n_pin <= 1'b0;
      for (int i = 0; i < beats; i++) begin
         tick(1);
         // unused upper lines toggle in single mode so they cannot pass by luck
         sio_i <= quad ? sh[7:4] : {~sio_i[3:1], sh[7]};
         sh = quad ? {sh[3:0], 4'h0} : {sh[6:0], 1'b0};
         // 5 cycles low and 5 high: an 80 ns link clock
         tick(4);
         if (sio_oe != 4'h0) begin
            rd_q = quad ? {rd_q[11:0], sio_o} : {rd_q[14:0], sio_o[1]};
            oe_seen = sio_oe;
         end
         sclk_pin <= 1'b1;
         tick(5);
         sclk_pin <= 1'b0;
      end
      tick(5);
      cs_n_pin <= 1'b1;
      sio_i <= ~sio_i;
      tick(8);
   endtask
endmodule

// ---- testbench/tb_otp_security_protect_ctrl.sv ----
`timescale 1ns/100ps
module tb_otp_security_protect_ctrl;
   import osp_pkg::*;
   localparam int LIMIT = 20000;
   logic       clk_sys = 1'b0;
   logic       rstn, cs_n_pin, sclk_pin, wp_n_pin, factory_lock, quad_command_mode;
   logic       bp_range_hit, persistent_protect_bit, volatile_protect_bit;
   logic       write_enable_latch, seen;
   logic [3:0] sio_i, sio_o, sio_oe;
   logic [7:0] security_register;
   osp_evt_t   evt;
   osp_prot_t  prot;
   int         err_total = 0;
   int         checks_done = 0;
   int         cycles = 0;
   // next-to-last entry: fail and success in one cycle, the set must win; the last entry then clears it
   logic [7:0] ev_tab [11] = '{8'h80, 8'h20, 8'h40, 8'h20, 8'h10, 8'h08, 8'h02, 8'h04,
                               8'h01, 8'hc0, 8'h40};
   logic [7:0] ex_tab [11] = '{8'h41, 8'h61, 8'h01, 8'h21, 8'h01, 8'h09, 8'h0d, 8'h05,
                               8'h01, 8'h41, 8'h01};

   always #4 clk_sys = ~clk_sys;

   osp_ctrl dut_u (
      .clk_sys(clk_sys), .rstn(rstn), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
      .sio_i(sio_i), .sio_o(sio_o), .sio_oe(sio_oe), .wp_n_pin(wp_n_pin),
      .factory_lock(factory_lock), .quad_command_mode(quad_command_mode),
      .bp_range_hit(bp_range_hit), .persistent_protect_bit(persistent_protect_bit),
      .volatile_protect_bit(volatile_protect_bit), .evt(evt), .prot(prot),
      .write_enable_latch(write_enable_latch), .security_register(security_register)
   );

   osp_host_model host_u (
      .clk_sys(clk_sys), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .sio_i(sio_i),
      .sio_o(sio_o), .sio_oe(sio_oe), .quad_command_mode(quad_command_mode)
   );

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen_v, input logic [15:0] exp_v);
      checks_done++;
      if (seen_v !== exp_v) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen_v, exp_v);
      end
   endtask

   // frame through the host, then sample away from the clock edge
   task automatic cmd(input logic [7:0] op, input int beats, input logic quad);
      host_u.frame(op, beats, quad);
      @(negedge clk_sys);
   endtask

   // pins are {wp_n, bp hit, persistent, volatile}; pin path is synced, so wait
   task automatic prot_chk(input logic [3:0] pins, input logic exp_v);
      @(posedge clk_sys);
      {wp_n_pin, bp_range_hit, persistent_protect_bit, volatile_protect_bit} <= pins;
      repeat (6) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(prot.array_wp, exp_v);
   endtask

   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         err_total++;
         tally_and_finish();
      end
   end

   initial begin
      rstn = 1'b0;
      wp_n_pin = 1'b1;
      factory_lock = 1'b1;
      bp_range_hit = 1'b0;
      persistent_protect_bit = 1'b0;
      volatile_protect_bit = 1'b0;
      evt = '0;
      seen = 1'b0;
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (4) begin
         @(negedge clk_sys);
         seen = seen | prot.volatile_preset;
      end
      chk(seen, 1'b1);
      chk(security_register, 8'h01);
      cmd(OSP_OP_READ_SEC, 24, 1'b0);
      chk(host_u.rd_q, 16'h0101);
      chk(host_u.oe_seen, 4'h2);
      for (int i = 0; i < 11; i++) begin
         @(posedge clk_sys);
         evt <= ev_tab[i];
         @(posedge clk_sys);
         evt <= '0;
         @(negedge clk_sys);
         chk(security_register, ex_tab[i]);
      end
      cmd(OSP_OP_WRITE_SEC, 8, 1'b0);
      chk(security_register, 8'h01);
      cmd(OSP_OP_ENTER_OTP, 8, 1'b0);
      chk(prot.otp_mode, 1'b1);
      chk(prot.otp_write_ok, 1'b1);
      cmd(OSP_OP_WRITE_ENABLE_CMD, 8, 1'b0);
      cmd(OSP_OP_WRITE_SEC, 9, 1'b0);
      chk(security_register, 8'h01);
      chk(write_enable_latch, 1'b1);
      cmd(OSP_OP_WRITE_SEC, 8, 1'b0);
      chk(security_register, 8'h03);
      chk(prot.otp_write_ok, 1'b0);
      chk(prot.otp_mode, 1'b1);
      cmd(OSP_OP_READ_SEC, 6, 1'b1);
      chk(host_u.rd_q, 16'h0303);
      chk(host_u.oe_seen, 4'hf);
      cmd(OSP_OP_EXIT_OTP, 2, 1'b1);
      chk(prot.otp_mode, 1'b0);
      prot_chk(4'b0011, 1'b0);
      prot_chk(4'b1100, 1'b1);
      chk(prot.indiv_cmd_en, 1'b0);
      cmd(OSP_OP_MODE_SEL, 8, 1'b0);
      chk(security_register, 8'h03);
      cmd(OSP_OP_WRITE_ENABLE_CMD, 8, 1'b0);
      cmd(OSP_OP_MODE_SEL, 8, 1'b0);
      chk(security_register, 8'h83);
      chk(prot.indiv_cmd_en, 1'b1);
      prot_chk(4'b1100, 1'b0);
      prot_chk(4'b1110, 1'b1);
      prot_chk(4'b1101, 1'b1);
      prot_chk(4'b0100, 1'b1);
      tally_and_finish();
   end
endmodule
